//--- core/quarter_sequencer.v
/*
 Quarter sequencer: divides the core clock into four one-hot quarters.
 Assumes clk_i is the oscillator clock and rstn_i an asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "skip_exec_defs.vh"
module quarter_sequencer (
  input wire clk_i,
  input wire rstn_i,
  output wire [3:0] quarter_o
);
  reg [3:0] quarter;
  // Rotates decode, read, process and write quarters, one per clock.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      quarter <= `RESET_QUARTER;
    end else begin
      quarter <= {quarter[2:0], quarter[3]};
    end
  end
  assign quarter_o = quarter;
endmodule
`default_nettype wire

//--- core/skip_and_file_op_execution.v
/*
 Executes the bit-test-skip-when-clear, decrement-skip-when-zero and
 complement-file-value instructions over four-quarter instruction cycles.
 Assumes the fetch path presents the current instruction word on instr_i
 through the whole cycle and file data on file_rdata_i in the read quarter.
*/
// Function
// - Bit test finding a one lets the next instruction run.
// - Bit test finding a zero discards the next instruction as a no-op.
// - Skipping bit test takes two instruction cycles, otherwise one.
// - Decrement-skip subtracts one from the file register, one or two cycles.
// - Decrement result goes to accumulator when destination clear, file when set.
// - Zero decrement result replaces next instruction by a no-op.
// - Zero decrement result takes two instruction cycles.
// - Complement inverts all file bits in one instruction cycle.
// - Complement result goes to file when destination set, accumulator when clear.
// - Each instruction cycle is four clocks: decode, read, process, write.
// - Byte operations route result by destination select bit.
`timescale 1ns/1ps
`default_nettype none
`include "skip_exec_defs.vh"
module skip_and_file_op_execution (
  input wire clk_i,
  input wire rstn_i,
  input wire [13:0] instr_i,
  input wire [7:0] file_rdata_i,
  output wire [6:0] file_addr_o,
  output wire file_rd_o,
  output reg file_we_o,
  output reg [7:0] file_wdata_o,
  output reg [7:0] acc_o,
  output reg [7:0] status_o,
  output wire cycle_end_o,
  output reg nop_cycle_o,
  output reg busy_o
);
  /*****************************************************************/
  /* Quarter timing                                                */
  /*****************************************************************/
  wire [3:0] quarter;
  quarter_sequencer u_seq (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .quarter_o(quarter)
  );
  localparam Q_DECODE = 0;
  localparam Q_READ = 1;
  localparam Q_PROCESS = 2;
  localparam Q_WRITE = 3;
  assign cycle_end_o = quarter[Q_WRITE];
  /*****************************************************************/
  /* Decode                                                        */
  /*****************************************************************/
  wire is_dec = instr_i[`OPC_HI:`OPC_LO] == `OPC_DECREMENT_SKIP;
  wire is_com = instr_i[`OPC_HI:`OPC_LO] == `OPC_COMPLEMENT;
  wire is_btc = instr_i[`BIT_OPC_HI:`BIT_OPC_LO] == `OPC_BIT_TEST_CLEAR;
  wire dest_file = instr_i[`DEST_BIT];
  wire [2:0] bit_sel = instr_i[`BSEL_HI:`BSEL_LO];
  assign file_rd_o = quarter[Q_READ] & ~nop_cycle_o & (is_dec | is_com | is_btc);
  /*****************************************************************/
  /* File address register                                         */
  /*****************************************************************/
  // Holding the address until the next decode quarter ends lets a write back that
  // follows the write quarter still reach the register of its own instruction.
  reg [6:0] file_addr;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      file_addr <= `RESET_ADDR;
    end else if (quarter[Q_DECODE]) begin
      file_addr <= instr_i[`ADDR_HI:`ADDR_LO];
    end
  end
  assign file_addr_o = file_addr;
  /*****************************************************************/
  /* Operand capture                                               */
  /*****************************************************************/
  // The operand is taken at the edge that ends the read quarter.
  reg [7:0] operand;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      operand <= `RESET_DATA;
    end else if (quarter[Q_READ]) begin
      operand <= file_rdata_i;
    end
  end
  /*****************************************************************/
  /* Per-bit test for a clear bit                                  */
  /*****************************************************************/
  // The selected bit is tested through a one-hot mask so every bit has the same path.
  wire [7:0] bit_mask = 8'h01 << bit_sel;
  wire [7:0] bit_clear_hit;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_bit_test
      assign bit_clear_hit[g] = bit_mask[g] & ~operand[g];
    end
  endgenerate
  /*****************************************************************/
  /* Processing                                                    */
  /*****************************************************************/
  reg [7:0] result;
  reg skip_pending;
  reg [7:0] next_result;
  reg next_skip;
  always @* begin
    next_result = operand;
    next_skip = 1'b0;
    if (is_dec) begin
      next_result = operand - 8'h01;
      next_skip = next_result == 8'h00;
    end else if (is_com) begin
      next_result = ~operand;
    end else if (is_btc) begin
      next_skip = |bit_clear_hit;
    end
  end
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      result <= `RESET_DATA;
    end else if (quarter[Q_PROCESS] && !nop_cycle_o) begin
      result <= next_result;
    end
  end
  // Clearing in the write quarter keeps a stale skip out of the discard cycle.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      skip_pending <= 1'b0;
    end else if (quarter[Q_PROCESS] && !nop_cycle_o) begin
      skip_pending <= next_skip;
    end else if (quarter[Q_WRITE]) begin
      skip_pending <= 1'b0;
    end
  end
  /*****************************************************************/
  /* Write back                                                    */
  /*****************************************************************/
  wire write_now = quarter[Q_WRITE] & ~nop_cycle_o & (is_dec | is_com);
  wire result_zero = result == 8'h00;
  reg next_file_we;
  reg [7:0] next_file_wdata;
  reg [7:0] next_acc;
  reg [7:0] next_status;
  always @* begin
    next_file_we = 1'b0;
    next_file_wdata = file_wdata_o;
    next_acc = acc_o;
    next_status = status_o;
    if (write_now) begin
      if (dest_file) begin
        next_file_we = 1'b1;
        next_file_wdata = result;
      end else begin
        next_acc = result;
      end
      if (is_com) begin
        next_status[`ZERO_FLAG_BIT] = result_zero;
      end
    end
  end
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_o <= `RESET_ACC;
    end else begin
      acc_o <= next_acc;
    end
  end
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_o <= `RESET_STATUS;
    end else begin
      status_o <= next_status;
    end
  end
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      file_we_o <= 1'b0;
      file_wdata_o <= `RESET_DATA;
    end else begin
      file_we_o <= next_file_we;
      file_wdata_o <= next_file_wdata;
    end
  end
  /*****************************************************************/
  /* Execute and discard sequencing                                */
  /*****************************************************************/
  // A discard cycle runs all four quarters, so a skip always costs one whole cycle.
  localparam ST_EXECUTE = 2'h1;
  localparam ST_DISCARD = 2'h2;
  reg [1:0] exec_state;
  reg [1:0] next_exec_state;
  always @* begin
    next_exec_state = exec_state;
    case (exec_state)
      ST_EXECUTE: begin
        if (quarter[Q_WRITE] && skip_pending) begin
          next_exec_state = ST_DISCARD;
        end
      end
      ST_DISCARD: begin
        if (quarter[Q_WRITE]) begin
          next_exec_state = ST_EXECUTE;
        end
      end
      default: begin
        next_exec_state = ST_EXECUTE;
      end
    endcase
  end
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      exec_state <= ST_EXECUTE;
      nop_cycle_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      exec_state <= next_exec_state;
      nop_cycle_o <= next_exec_state == ST_DISCARD;
      busy_o <= next_exec_state == ST_DISCARD;
    end
  end
endmodule
`default_nettype wire

//--- core/skip_exec_defs.vh
/*
 Constants for the skip and complement execution block: opcode fields,
 quarter encodings, status bit position and reset values.
 Assumes a 14-bit instruction word and an 8-bit data path.
*/
`ifndef SKIP_EXEC_DEFS_VH
`define SKIP_EXEC_DEFS_VH
`define OPC_HI 13
`define OPC_LO 8
`define BIT_OPC_HI 13
`define BIT_OPC_LO 10
`define DEST_BIT 7
`define ADDR_HI 6
`define ADDR_LO 0
`define BSEL_HI 9
`define BSEL_LO 7
`define OPC_DECREMENT_SKIP 6'h0B
`define OPC_COMPLEMENT 6'h09
`define OPC_BIT_TEST_CLEAR 4'h6
`define QUARTERS_PER_CYCLE 4
`define ZERO_FLAG_BIT 2
`define RESET_ACC 8'h00
`define RESET_STATUS 8'h00
`define RESET_QUARTER 4'h1
`define RESET_ADDR 7'h00
`define RESET_DATA 8'h00
`endif

//--- verif/file_model.sv
/* Data file model: 128 bytes, read while the read strobe is high.
   Assumes one clock; released data shows the inverse of the last read. */
`timescale 1ns/1ps
`default_nettype none
module file_model (
  input wire logic clk_i,
  input wire logic [6:0] addr_i,
  input wire logic rd_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:127];
  logic [7:0] last = 8'h00;
  always @(posedge clk_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
    if (rd_i) last <= mem[addr_i];
  end
  assign rdata_o = rd_i ? mem[addr_i] : ~last;
endmodule
`default_nettype wire

//--- verif/skip_exec_chk.sv
/* Port checker for the skip and complement block.
   Assumes binding to its top module. */
`timescale 1ns/1ps
`default_nettype none
`include "skip_exec_defs.vh"
module skip_exec_chk (
  input wire logic clk_i, rstn_i, file_rd_o, file_we_o, cycle_end_o, nop_cycle_o, busy_o,
  input wire logic [13:0] instr_i,
  input wire logic [7:0] file_rdata_i, file_wdata_o, acc_o, status_o
);
  logic [7:0] rd;
  always @(posedge clk_i) if (file_rd_o) rd <= file_rdata_i;
  wire logic go = cycle_end_o && !nop_cycle_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_ce; cycle_end_o |=> !cycle_end_o [*3] ##1 cycle_end_o; endproperty
  a_ce: assert property (p_ce) else $error("bad cycle length");
  property p_rd; file_rd_o |-> ##2 cycle_end_o; endproperty
  a_rd: assert property (p_rd) else $error("read off quarter");
  property p_nop; $rose(nop_cycle_o) |-> nop_cycle_o [*4] ##1 !nop_cycle_o; endproperty
  a_nop: assert property (p_nop) else $error("bad no-op cycle");
  property p_ign; nop_cycle_o |-> !file_rd_o && (!file_we_o || $rose(nop_cycle_o)); endproperty
  a_ign: assert property (p_ign) else $error("access in no-op");
  property p_busy; busy_o == nop_cycle_o; endproperty
  a_busy: assert property (p_busy) else $error("busy mismatch");
  property p_com; go && instr_i[13:8] == `OPC_COMPLEMENT |=> file_we_o == $past(instr_i[7])
    && ($past(instr_i[7]) ? file_wdata_o : acc_o) == ~rd && status_o[2] == (rd == 8'hFF)
    && !nop_cycle_o; endproperty
  a_com: assert property (p_com) else $error("bad complement");
  property p_dec; go && instr_i[13:8] == `OPC_DECREMENT_SKIP |=> $stable(status_o)
    && ($past(instr_i[7]) ? file_wdata_o : acc_o) == rd - 8'h01
    && nop_cycle_o == (rd == 8'h01); endproperty
  a_dec: assert property (p_dec) else $error("bad decrement");
  property p_bit; go && instr_i[13:10] == `OPC_BIT_TEST_CLEAR |=> !file_we_o && $stable(acc_o)
    && nop_cycle_o == !rd[$past(instr_i[9:7])] && $stable(status_o); endproperty
  a_bit: assert property (p_bit) else $error("bad bit test");
endmodule
bind skip_and_file_op_execution skip_exec_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .file_rd_o(file_rd_o), .file_we_o(file_we_o), .cycle_end_o(cycle_end_o),
  .nop_cycle_o(nop_cycle_o), .busy_o(busy_o), .instr_i(instr_i), .file_rdata_i(file_rdata_i),
  .file_wdata_o(file_wdata_o), .acc_o(acc_o), .status_o(status_o));
`default_nettype wire

//--- verif/testbench.sv
/* Self-checking bench with a reference model of the three instructions.
   Assumes the data file model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "skip_exec_defs.vh"
module testbench;
  logic clk_i = 0, rstn_i = 0, skip;
  logic [13:0] instr_i = 14'h0000;
  wire logic [7:0] file_rdata_i, file_wdata_o, acc_o, status_o;
  wire logic [6:0] file_addr_o;
  wire logic file_rd_o, file_we_o, cycle_end_o, nop_cycle_o, busy_o;
  int failures = 0, comparisons = 0, seed = 32'hE666, i, k;
  logic [31:0] r;
  logic [7:0] m [0:127];
  logic [7:0] v, res, e_acc = 8'h00, e_st = 8'h00;
  initial forever #25 clk_i = ~clk_i;
  skip_and_file_op_execution i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .instr_i(instr_i),
    .file_rdata_i(file_rdata_i), .file_addr_o(file_addr_o), .file_rd_o(file_rd_o),
    .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .acc_o(acc_o), .status_o(status_o),
    .cycle_end_o(cycle_end_o), .nop_cycle_o(nop_cycle_o), .busy_o(busy_o));
  file_model i_mem (.clk_i(clk_i), .addr_i(file_addr_o), .rd_i(file_rd_o), .we_i(file_we_o),
    .wdata_i(file_wdata_o), .rdata_o(file_rdata_i));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("%0d failures, %0d comparisons", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #(80 * 8 * 50 * 4);
    failures++;
    conclude();
  end
  initial begin
    for (i = 0; i < 128; i++) begin
      m[i] = i[7:0];
      i_mem.mem[i] = i[7:0];
    end
    repeat (5) @(posedge clk_i);
    #1 rstn_i = 1;
    @(posedge clk_i iff cycle_end_o);
    #1;
    for (i = 0; i < 80; i++) begin
      r = $random(seed);
      k = r[12:11] % 3;
      v = m[r[2:0]];
      instr_i = k == 0 ? {`OPC_BIT_TEST_CLEAR, r[9:7], 4'h0, r[2:0]} :
        {k == 1 ? `OPC_DECREMENT_SKIP : `OPC_COMPLEMENT, r[10], 4'h0, r[2:0]};
      res = k == 2 ? ~v : v - 8'h01;
      skip = k == 0 ? !v[r[9:7]] : k == 1 && res == 8'h00;
      if (k != 0 && r[10])
        m[r[2:0]] = res;
      else if (k != 0)
        e_acc = res;
      if (k == 2)
        e_st[`ZERO_FLAG_BIT] = res == 8'h00;
      @(posedge clk_i iff cycle_end_o);
      #1;
      chk(acc_o, e_acc);
      chk(status_o, e_st);
      chk({6'h00, file_we_o, nop_cycle_o}, {6'h00, k != 0 && r[10], skip});
      if (file_we_o) chk(file_wdata_o, res);
      if (skip) begin
        instr_i = r[31:18];
        @(posedge clk_i iff cycle_end_o);
        #1;
        chk({6'h00, file_we_o, nop_cycle_o}, 8'h00);
        chk(acc_o, e_acc);
      end
      $display("test %0d done", i);
    end
    instr_i = 14'h0000;
    @(posedge clk_i);
    #1 rstn_i = 0;
    #1 chk({4'h0, cycle_end_o, file_we_o, nop_cycle_o, busy_o}, 8'h00);
    repeat (5) @(posedge clk_i);
    #1 rstn_i = 1;
    repeat (3) @(posedge clk_i);
    #1 chk({7'h00, cycle_end_o}, 8'h01);
    $display("test reset done");
    conclude();
  end
endmodule
`default_nettype wire
